// ==== hw/asp_fifo.sv ====
// Eight-entry character queue; a pop loads the head word into the read register
module asp_fifo
	import asp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	asp_fifo_if.store f
);
	typedef struct packed {
		logic [7:0][8:0] mem;
		logic [2:0] wr_ptr;
		logic [2:0] rd_ptr;
		logic [3:0] count;
		logic [8:0] rdata;
	} asp_fifo_state_t;

	asp_fifo_state_t s_r;
	asp_fifo_state_t s_nxt;
	logic do_push;
	logic do_pop;

	// Queue update; a push into a full queue is dropped, so callers check count first
	always_comb
	begin
		s_nxt = s_r;
		do_push = f.push && (s_r.count != ASP_FIFO_DEPTH);
		do_pop = f.pop && (s_r.count != 4'h0);
		if (f.flush)
		begin
			s_nxt.wr_ptr = 3'h0;
			s_nxt.rd_ptr = 3'h0;
			s_nxt.count = 4'h0;
		end
		else
		begin
			if (do_push)
			begin
				s_nxt.mem[s_r.wr_ptr] = f.wdata;
				s_nxt.wr_ptr = s_r.wr_ptr + 3'h1;
			end
			if (do_pop)
			begin
				s_nxt.rdata = s_r.mem[s_r.rd_ptr];
				s_nxt.rd_ptr = s_r.rd_ptr + 3'h1;
			end
			if (do_push && !do_pop)
				s_nxt.count = s_r.count + 4'h1;
			else if (do_pop && !do_push)
				s_nxt.count = s_r.count - 4'h1;
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign f.rdata = s_r.rdata;
	assign f.count = s_r.count;
endmodule

// ==== hw/asp_fifo_if.sv ====
// Connection between the core and one of its character queues
interface asp_fifo_if;
	logic push;
	logic [8:0] wdata;
	logic pop;
	logic flush;
	logic [8:0] rdata;
	logic [3:0] count;
	modport user (output push, output wdata, output pop, output flush, input rdata, input count);
	modport store (input push, input wdata, input pop, input flush, output rdata, output count);
endinterface

// ==== hw/asp_pkg.sv ====
// Shared constants, field positions and state types of the serial port block
package asp_pkg;
	// Register byte offsets
	localparam logic [7:0] ASP_OFS_MODE = 8'h00;
	localparam logic [7:0] ASP_OFS_STATUS = 8'h04;
	localparam logic [7:0] ASP_OFS_TXDATA = 8'h08;
	localparam logic [7:0] ASP_OFS_RXDATA = 8'h0c;
	localparam logic [7:0] ASP_OFS_DIVISOR = 8'h10;
	localparam logic [7:0] ASP_OFS_UNMAPPED = 8'hff;
	// Mode register field positions
	localparam int ASP_MODE_ON = 15;
	localparam int ASP_MODE_IDLE_STOP = 13;
	localparam int ASP_MODE_IR_EN = 12;
	localparam int ASP_MODE_RTS_MODE = 11;
	localparam int ASP_MODE_PIN_SET = 8;
	localparam int ASP_MODE_WAKE = 7;
	localparam int ASP_MODE_LOOPBACK = 6;
	localparam int ASP_MODE_AUTO_RATE = 5;
	localparam int ASP_MODE_RX_INV = 4;
	localparam int ASP_MODE_HIGH_SPEED = 3;
	localparam int ASP_MODE_FRAMING = 1;
	localparam int ASP_MODE_STOP_COUNT = 0;
	localparam logic [15:0] ASP_MODE_WR_MASK = 16'hbbff;
	localparam logic [15:0] ASP_MODE_RESET = 16'h0000;
	localparam logic [15:0] ASP_DIV_RESET = 16'h0040;
	// Status register field positions
	localparam int ASP_STA_AUTO_MATCH = 24;
	localparam int ASP_STA_MATCH = 16;
	localparam int ASP_STA_TX_IRQ_SEL = 14;
	localparam int ASP_STA_TX_INV = 13;
	localparam int ASP_STA_RX_EN = 12;
	localparam int ASP_STA_BREAK = 11;
	localparam int ASP_STA_TX_EN = 10;
	localparam int ASP_STA_RX_IRQ_SEL = 6;
	localparam int ASP_STA_ADDR_DET = 5;
	localparam int ASP_STA_OVERRUN = 1;
	// Field codes
	localparam logic [1:0] ASP_PINS_TXRX = 2'h0;
	localparam logic [1:0] ASP_PINS_RTS = 2'h1;
	localparam logic [1:0] ASP_PINS_FLOW = 2'h2;
	localparam logic [1:0] ASP_PINS_BCLK = 2'h3;
	localparam logic [1:0] ASP_FRAME_8N = 2'h0;
	localparam logic [1:0] ASP_FRAME_9N = 2'h3;
	localparam logic [1:0] ASP_TXI_FREE = 2'h0;
	localparam logic [1:0] ASP_TXI_DONE = 2'h1;
	localparam logic [1:0] ASP_TXI_EMPTY = 2'h2;
	localparam logic [1:0] ASP_RXI_ANY = 2'h0;
	localparam logic [1:0] ASP_RXI_HALF = 2'h1;
	localparam logic [1:0] ASP_RXI_MOST = 2'h2;
	localparam logic [3:0] ASP_RXI_ANY_LVL = 4'h1;
	localparam logic [3:0] ASP_RXI_HALF_LVL = 4'h4;
	localparam logic [3:0] ASP_RXI_MOST_LVL = 4'h6;
	// Buffer and timing counts (ticks of the oversampling clock)
	localparam int ASP_FIFO_WIDTH = 9;
	localparam logic [3:0] ASP_FIFO_DEPTH = 4'h8;
	localparam logic [3:0] ASP_BREAK_BITS = 4'hc;
	localparam logic [3:0] ASP_OS_STD_LAST = 4'hf;
	localparam logic [3:0] ASP_OS_FAST_LAST = 4'h3;
	localparam logic [3:0] ASP_OS_STD_MID = 4'h7;
	localparam logic [3:0] ASP_OS_FAST_MID = 4'h1;
	localparam logic [3:0] ASP_IR_STD_WIDTH = 4'h3;
	localparam logic [3:0] ASP_IR_FAST_WIDTH = 4'h1;
	localparam int ASP_MEAS_STD_SHIFT = 4;
	localparam int ASP_MEAS_FAST_SHIFT = 2;
	// State machines
	typedef enum logic [4:0] {
		ASP_T_IDLE = 5'b00001,
		ASP_T_LOAD = 5'b00010,
		ASP_T_START = 5'b00100,
		ASP_T_DATA = 5'b01000,
		ASP_T_STOP = 5'b10000
	} asp_tx_state_t;
	typedef enum logic [4:0] {
		ASP_R_IDLE = 5'b00001,
		ASP_R_START = 5'b00010,
		ASP_R_DATA = 5'b00100,
		ASP_R_STOP = 5'b01000,
		ASP_R_MEAS = 5'b10000
	} asp_rx_state_t;
endpackage

// ==== hw/asp_rate_div.sv ====
// Divisor counter giving one-cycle enables at the oversampling rate
module asp_rate_div
	import asp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic [15:0] divisor_i,
	output logic tick_o
);
	typedef struct packed {
		logic [15:0] count;
		logic tick;
	} asp_div_state_t;

	asp_div_state_t s_r;
	asp_div_state_t s_nxt;

	// One tick every divisor+1 clocks; held at zero while stopped to save toggling
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (!run_i)
			s_nxt.count = 16'h0000;
		else if (s_r.count >= divisor_i)
		begin
			s_nxt.count = 16'h0000;
			s_nxt.tick = 1'b1;
		end
		else
			s_nxt.count = s_r.count + 16'h0001;
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign tick_o = s_r.tick;
endmodule

// ==== hw/asp_top.sv ====
// Asynchronous serial port: registers, transmitter, receiver and pin control
//
// Added by the designer: the register addresses and register access over AHB-Lite.
module asp_top
	import asp_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	output logic [31:0] HRDATA_O,
	input wire logic IDLE_MODE_I,
	input wire logic SLEEP_MODE_I,
	input wire logic SERIAL_IN_I,
	input wire logic CLEAR_TO_SEND_N_I,
	output logic SERIAL_OUT_O,
	output logic SERIAL_OUT_OE_N_O,
	output logic REQUEST_TO_SEND_N_O,
	output logic REQUEST_TO_SEND_OE_N_O,
	output logic RATE_CLOCK_O,
	output logic RATE_CLOCK_OE_N_O,
	output logic SERIAL_IN_OWN_O,
	output logic CLEAR_TO_SEND_OWN_O,
	output logic WAKE_O,
	output logic TX_IRQ_O,
	output logic RX_IRQ_O
);
	typedef struct packed {
		logic [15:0] mode;
		logic auto_match_enable;
		logic [7:0] match;
		logic [1:0] transmit_irq_select;
		logic transmit_polarity_invert;
		logic receiver_enable;
		logic break_request;
		logic transmitter_enable;
		logic [1:0] receive_irq_select;
		logic addr_detect;
		logic receive_overrun_flag;
		logic parity_err;
		logic frame_err;
		logic [15:0] divisor;
		logic wr_pend;
		logic rd_wait;
		logic [7:0] bus_addr;
		logic [31:0] rdata;
		asp_tx_state_t tx_state;
		logic [12:0] tx_shift;
		logic [3:0] tx_bits;
		logic tx_stop2;
		logic tx_is_break;
		logic [3:0] tx_tick;
		logic tx_bit;
		logic tx_pin;
		asp_rx_state_t rx_state;
		logic [8:0] rx_shift;
		logic [3:0] rx_bits;
		logic [3:0] rx_tick;
		logic rx_prev;
		logic addr_matched;
		logic [19:0] meas_count;
		logic [3:0] ir_hold;
		logic rate_clk;
		logic wake;
	} asp_core_state_t;

	asp_core_state_t s_r;
	asp_core_state_t s_nxt;
	asp_fifo_if txf ();
	asp_fifo_if rxf ();
	logic tick;
	logic on;
	logic run;
	logic fast;
	logic [1:0] framing;
	logic [1:0] pin_set;
	logic [3:0] os_last;
	logic [3:0] os_mid;
	logic [3:0] frame_bits;
	logic parity_on;
	logic rx_line;
	logic rx_level;
	logic ir_pulse_in;
	logic tx_push;
	logic tx_pop;
	logic rx_push;
	logic rx_pop;
	logic rx_flush;
	logic [8:0] rx_word;
	logic [31:0] status_word;

	// Decoded mode fields
	assign on = s_r.mode[ASP_MODE_ON];
	assign run = on && !(s_r.mode[ASP_MODE_IDLE_STOP] && IDLE_MODE_I);
	assign fast = s_r.mode[ASP_MODE_HIGH_SPEED];
	assign framing = s_r.mode[ASP_MODE_FRAMING +: 2];
	assign pin_set = s_r.mode[ASP_MODE_PIN_SET +: 2];
	assign os_last = fast ? ASP_OS_FAST_LAST : ASP_OS_STD_LAST;
	assign os_mid = fast ? ASP_OS_FAST_MID : ASP_OS_STD_MID;
	assign parity_on = framing[1] ^ framing[0];
	assign frame_bits = (framing == ASP_FRAME_8N) ? 4'h8 : 4'h9;

	// Receive line after polarity, infrared decoding, loopback and enable
	assign rx_level = SERIAL_IN_I ^ s_r.mode[ASP_MODE_RX_INV];
	assign ir_pulse_in = !rx_level;
	always_comb
	begin
		if (!s_r.receiver_enable)
			rx_line = 1'b1;
		else if (s_r.mode[ASP_MODE_LOOPBACK])
			rx_line = s_r.tx_bit;
		else if (s_r.mode[ASP_MODE_IR_EN])
			rx_line = !(ir_pulse_in || (s_r.ir_hold != 4'h0));
		else
			rx_line = rx_level;
	end

	assign status_word = {7'h00, s_r.auto_match_enable, s_r.match, s_r.transmit_irq_select,
		s_r.transmit_polarity_invert, s_r.receiver_enable, s_r.break_request,
		s_r.transmitter_enable, txf.count == ASP_FIFO_DEPTH,
		(s_r.tx_state == ASP_T_IDLE) && (txf.count == 4'h0),
		s_r.receive_irq_select, s_r.addr_detect, s_r.rx_state == ASP_R_IDLE,
		s_r.parity_err, s_r.frame_err, s_r.receive_overrun_flag, rxf.count != 4'h0};

	// Next-state logic for bus slave, transmitter and receiver
	always_comb
	begin
		s_nxt = s_r;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		rx_flush = 1'b0;
		rx_word = 9'h000;
		// Address phase; reads take one wait cycle so read data leave a flip-flop
		s_nxt.wr_pend = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
		s_nxt.rd_wait = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;
		if (HADDR_I[31:8] == 24'h000000)
			s_nxt.bus_addr = HADDR_I[7:0];
		else
			s_nxt.bus_addr = ASP_OFS_UNMAPPED;
		if (s_nxt.rd_wait && (s_nxt.bus_addr == ASP_OFS_RXDATA))
			rx_pop = 1'b1;
		// Read data capture
		if (s_r.rd_wait)
		begin
			if (s_r.bus_addr == ASP_OFS_MODE)
				s_nxt.rdata = {16'h0000, s_r.mode};
			else if (s_r.bus_addr == ASP_OFS_STATUS)
				s_nxt.rdata = status_word;
			else if (s_r.bus_addr == ASP_OFS_RXDATA)
				s_nxt.rdata = {23'h000000, rxf.rdata};
			else if (s_r.bus_addr == ASP_OFS_DIVISOR)
				s_nxt.rdata = {16'h0000, s_r.divisor};
			else
				s_nxt.rdata = 32'h00000000;
		end
		// Write data phase
		if (s_r.wr_pend)
		begin
			if (s_r.bus_addr == ASP_OFS_MODE)
				s_nxt.mode = HWDATA_I[15:0] & ASP_MODE_WR_MASK;
			else if (s_r.bus_addr == ASP_OFS_STATUS)
			begin
				s_nxt.auto_match_enable = HWDATA_I[ASP_STA_AUTO_MATCH];
				s_nxt.match = HWDATA_I[ASP_STA_MATCH +: 8];
				s_nxt.transmit_irq_select = HWDATA_I[ASP_STA_TX_IRQ_SEL +: 2];
				s_nxt.transmit_polarity_invert = HWDATA_I[ASP_STA_TX_INV];
				s_nxt.receiver_enable = HWDATA_I[ASP_STA_RX_EN];
				s_nxt.break_request = HWDATA_I[ASP_STA_BREAK];
				s_nxt.transmitter_enable = HWDATA_I[ASP_STA_TX_EN];
				s_nxt.receive_irq_select = HWDATA_I[ASP_STA_RX_IRQ_SEL +: 2];
				s_nxt.addr_detect = HWDATA_I[ASP_STA_ADDR_DET];
				rx_flush = s_r.receive_overrun_flag && !HWDATA_I[ASP_STA_OVERRUN];
			end
			else if (s_r.bus_addr == ASP_OFS_TXDATA)
				tx_push = on && s_r.transmitter_enable && (txf.count != ASP_FIFO_DEPTH);
			else if (s_r.bus_addr == ASP_OFS_DIVISOR)
				s_nxt.divisor = HWDATA_I[15:0];
		end

		// Transmitter
		if (run)
		begin
			if (tick && (s_r.tx_state != ASP_T_IDLE) && (s_r.tx_state != ASP_T_LOAD))
				s_nxt.tx_tick = (s_r.tx_tick == os_last) ? 4'h0 : s_r.tx_tick + 4'h1;
			case (s_r.tx_state)
				ASP_T_IDLE:
				begin
					s_nxt.tx_tick = 4'h0;
					if (s_r.transmitter_enable && s_r.break_request)
					begin
						s_nxt.tx_shift = 13'h0000;
						s_nxt.tx_bits = ASP_BREAK_BITS;
						s_nxt.tx_is_break = 1'b1;
						s_nxt.tx_state = ASP_T_START;
					end
					else if (s_r.transmitter_enable && (txf.count != 4'h0) &&
						((pin_set != ASP_PINS_FLOW) || !CLEAR_TO_SEND_N_I))
					begin
						tx_pop = 1'b1;
						s_nxt.tx_state = ASP_T_LOAD;
					end
				end
				ASP_T_LOAD:
				begin
					s_nxt.tx_is_break = 1'b0;
					s_nxt.tx_bits = frame_bits;
					if (framing == ASP_FRAME_9N)
						s_nxt.tx_shift = {4'h0, txf.rdata};
					else if (parity_on)
						s_nxt.tx_shift = {4'h0, (^txf.rdata[7:0]) ^ framing[1], txf.rdata[7:0]};
					else
						s_nxt.tx_shift = {5'h00, txf.rdata[7:0]};
					s_nxt.tx_state = ASP_T_START;
				end
				ASP_T_START:
				begin
					if (tick && (s_r.tx_tick == os_last))
						s_nxt.tx_state = ASP_T_DATA;
				end
				ASP_T_DATA:
				begin
					if (tick && (s_r.tx_tick == os_last))
					begin
						s_nxt.tx_shift = {1'b0, s_r.tx_shift[12:1]};
						s_nxt.tx_bits = s_r.tx_bits - 4'h1;
						s_nxt.tx_stop2 = s_r.mode[ASP_MODE_STOP_COUNT] && !s_r.tx_is_break;
						if (s_r.tx_bits == 4'h1)
							s_nxt.tx_state = ASP_T_STOP;
					end
				end
				ASP_T_STOP:
				begin
					if (tick && (s_r.tx_tick == os_last))
					begin
						if (s_r.tx_stop2)
							s_nxt.tx_stop2 = 1'b0;
						else
						begin
							s_nxt.tx_state = ASP_T_IDLE;
							if (s_r.tx_is_break)
								s_nxt.break_request = 1'b0;
						end
					end
				end
				default:
					s_nxt.tx_state = ASP_T_IDLE;
			endcase
		end
		// Disabling aborts the frame in flight; the queue is flushed by the same term
		if (!on || !s_r.transmitter_enable)
			s_nxt.tx_state = ASP_T_IDLE;
		if (s_nxt.tx_state == ASP_T_START)
			s_nxt.tx_bit = 1'b0;
		else if (s_nxt.tx_state == ASP_T_DATA)
			s_nxt.tx_bit = s_nxt.tx_shift[0];
		else
			s_nxt.tx_bit = 1'b1;
		// Pin level: short pulse in the first part of each zero bit when coding is on
		if (s_r.mode[ASP_MODE_IR_EN])
			s_nxt.tx_pin = (!s_nxt.tx_bit && (s_nxt.tx_tick <
				(fast ? ASP_IR_FAST_WIDTH : ASP_IR_STD_WIDTH))) ^
				s_r.transmit_polarity_invert;
		else
			s_nxt.tx_pin = s_nxt.tx_bit ^ s_r.transmit_polarity_invert;

		// Receiver
		if (run)
		begin
			s_nxt.rx_prev = rx_line;
			if (ir_pulse_in)
				s_nxt.ir_hold = os_last;
			else if (tick && (s_r.ir_hold != 4'h0))
				s_nxt.ir_hold = s_r.ir_hold - 4'h1;
			if (tick && ((s_r.rx_state == ASP_R_START) || (s_r.rx_state == ASP_R_DATA) ||
				(s_r.rx_state == ASP_R_STOP)))
				s_nxt.rx_tick = (s_r.rx_tick == os_last) ? 4'h0 : s_r.rx_tick + 4'h1;
			case (s_r.rx_state)
				ASP_R_IDLE:
				begin
					s_nxt.rx_tick = 4'h0;
					s_nxt.meas_count = 20'h00000;
					if (s_r.rx_prev && !rx_line)
						s_nxt.rx_state = s_r.mode[ASP_MODE_AUTO_RATE] ? ASP_R_MEAS : ASP_R_START;
				end
				ASP_R_START:
				begin
					// A start bit gone by mid-period is a glitch, not a character
					if (tick && (s_r.rx_tick == os_mid))
					begin
						s_nxt.rx_tick = 4'h0;
						s_nxt.rx_bits = frame_bits;
						s_nxt.rx_state = rx_line ? ASP_R_IDLE : ASP_R_DATA;
					end
				end
				ASP_R_DATA:
				begin
					if (tick && (s_r.rx_tick == os_last))
					begin
						s_nxt.rx_shift = {rx_line, s_r.rx_shift[8:1]};
						s_nxt.rx_bits = s_r.rx_bits - 4'h1;
						if (s_r.rx_bits == 4'h1)
							s_nxt.rx_state = ASP_R_STOP;
					end
				end
				ASP_R_STOP:
				begin
					if (tick && (s_r.rx_tick == os_last))
					begin
						s_nxt.rx_state = ASP_R_IDLE;
						s_nxt.frame_err = !rx_line;
						s_nxt.parity_err = parity_on && ((^s_r.rx_shift) != framing[1]);
						if (framing == ASP_FRAME_9N)
							rx_word = s_r.rx_shift;
						else if (parity_on)
							rx_word = {1'b0, s_r.rx_shift[7:0]};
						else
							rx_word = {1'b0, s_r.rx_shift[8:1]};
						// Address filtering applies to nine-bit characters only
						if ((framing == ASP_FRAME_9N) && s_r.auto_match_enable)
						begin
							if (rx_word[8])
								s_nxt.addr_matched = (rx_word[7:0] == s_r.match);
							rx_push = rx_word[8] ? (rx_word[7:0] == s_r.match) : s_r.addr_matched;
						end
						else if ((framing == ASP_FRAME_9N) && s_r.addr_detect)
							rx_push = rx_word[8];
						else
							rx_push = 1'b1;
						// Characters arriving while overrun stands are dropped
						if (rx_push && (s_r.receive_overrun_flag || (rxf.count == ASP_FIFO_DEPTH)))
						begin
							s_nxt.receive_overrun_flag = 1'b1;
							rx_push = 1'b0;
						end
					end
				end
				ASP_R_MEAS:
				begin
					// Start bit length in clocks divided by the oversampling ratio
					if (rx_line)
					begin
						if (s_r.meas_count[19:ASP_MEAS_FAST_SHIFT + 1] != 17'h00000)
							s_nxt.divisor = fast ?
								s_r.meas_count[ASP_MEAS_FAST_SHIFT +: 16] - 16'h0001 :
								s_r.meas_count[ASP_MEAS_STD_SHIFT +: 16] - 16'h0001;
						s_nxt.mode[ASP_MODE_AUTO_RATE] = 1'b0;
						s_nxt.rx_tick = os_mid + 4'h1;
						s_nxt.rx_bits = frame_bits;
						s_nxt.rx_state = ASP_R_DATA;
					end
					else if (s_r.meas_count != 20'hfffff)
						s_nxt.meas_count = s_r.meas_count + 20'h00001;
				end
				default:
					s_nxt.rx_state = ASP_R_IDLE;
			endcase
		end
		// Clearing overrun empties queue and shifter; the clear wins over a character finishing the same cycle
		if (rx_flush && !(s_nxt.receive_overrun_flag && !s_r.receive_overrun_flag))
		begin
			s_nxt.receive_overrun_flag = 1'b0;
			s_nxt.rx_state = ASP_R_IDLE;
			s_nxt.rx_shift = 9'h000;
			rx_push = 1'b0;
		end
		else
			rx_flush = 1'b0;
		if (!on)
			s_nxt.rx_state = ASP_R_IDLE;

		// Rate clock output and sleep wake-up
		if (!on)
			s_nxt.rate_clk = 1'b0;
		else if (tick)
			s_nxt.rate_clk = !s_r.rate_clk;
		if (!SLEEP_MODE_I)
			s_nxt.wake = 1'b0;
		else if (on && s_r.mode[ASP_MODE_WAKE] && s_r.rx_prev && !rx_line)
			s_nxt.wake = 1'b1;
	end

	// State register
	always_ff @(posedge REF_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			s_r <= '0;
			s_r.mode <= ASP_MODE_RESET;
			s_r.divisor <= ASP_DIV_RESET;
			s_r.tx_state <= ASP_T_IDLE;
			s_r.rx_state <= ASP_R_IDLE;
			s_r.tx_bit <= 1'b1;
			s_r.tx_pin <= 1'b1;
			s_r.rx_prev <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// Queues; both are held empty while the port is off
	assign txf.push = tx_push;
	assign txf.wdata = HWDATA_I[8:0];
	assign txf.pop = tx_pop;
	assign txf.flush = !on || !s_r.transmitter_enable;
	assign rxf.push = rx_push;
	assign rxf.wdata = rx_word;
	assign rxf.pop = rx_pop;
	assign rxf.flush = !on || rx_flush;

	asp_fifo u_tx_fifo (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.f(txf)
	);

	asp_fifo u_rx_fifo (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.f(rxf)
	);

	asp_rate_div u_rate_div (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.run_i(run),
		.divisor_i(s_r.divisor),
		.tick_o(tick)
	);

	// Bus answers
	assign HREADYOUT_O = !s_r.rd_wait;
	assign HRESP_O = 1'b0;
	assign HRDATA_O = s_r.rdata;

	// Pin ownership; enables are low while the port drives
	assign SERIAL_OUT_O = s_r.tx_pin;
	assign SERIAL_OUT_OE_N_O = !(on && s_r.transmitter_enable);
	assign REQUEST_TO_SEND_N_O = s_r.mode[ASP_MODE_RTS_MODE] ?
		(s_r.tx_state == ASP_T_IDLE) : (rxf.count == ASP_FIFO_DEPTH);
	assign REQUEST_TO_SEND_OE_N_O = !(on && ((pin_set == ASP_PINS_RTS) ||
		(pin_set == ASP_PINS_FLOW)));
	assign RATE_CLOCK_O = s_r.rate_clk;
	assign RATE_CLOCK_OE_N_O = !(on && (pin_set == ASP_PINS_BCLK));
	assign SERIAL_IN_OWN_O = on && s_r.receiver_enable;
	assign CLEAR_TO_SEND_OWN_O = on && (pin_set == ASP_PINS_FLOW);
	assign WAKE_O = s_r.wake;

	// Interrupt levels from queue fill state, with transmitter idle added for the done select
	always_comb
	begin
		case (s_r.transmit_irq_select)
			ASP_TXI_FREE: TX_IRQ_O = on && (txf.count != ASP_FIFO_DEPTH);
			ASP_TXI_DONE: TX_IRQ_O = on && (s_r.tx_state == ASP_T_IDLE) && (txf.count == 4'h0);
			ASP_TXI_EMPTY: TX_IRQ_O = on && (txf.count == 4'h0);
			default: TX_IRQ_O = 1'b0;
		endcase
		case (s_r.receive_irq_select)
			ASP_RXI_ANY: RX_IRQ_O = rxf.count >= ASP_RXI_ANY_LVL;
			ASP_RXI_HALF: RX_IRQ_O = rxf.count >= ASP_RXI_HALF_LVL;
			ASP_RXI_MOST: RX_IRQ_O = rxf.count >= ASP_RXI_MOST_LVL;
			default: RX_IRQ_O = 1'b0;
		endcase
	end
endmodule

// ==== tb/asp_peer.sv ====
// Behavioural serial peer sending and receiving 8N1 characters
module asp_peer
	#(parameter int BIT_CLKS = 8)
(
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle high between frames
	initial line_o = 1'b1;
	// Start, eight data bits LSB first, stop
	task automatic send(input logic [7:0] c);
		logic [9:0] f;
		f = {1'b1, c, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			line_o <= f[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
	endtask
	// Mid-bit sampling after the start edge
	task automatic recv(output logic [7:0] c);
		@(negedge line_i);
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CLKS) @(posedge clk_i);
			c[i] = line_i;
		end
	endtask
endmodule

// ==== tb/asp_top_properties.sv ====
// Port-level timing checks for the serial port block
module asp_top_properties
	import asp_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	input wire logic HSEL_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic HREADY_I,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O,
	input wire logic SLEEP_MODE_I,
	input wire logic WAKE_O,
	input wire logic REQUEST_TO_SEND_OE_N_O,
	input wire logic RATE_CLOCK_OE_N_O,
	input wire logic CLEAR_TO_SEND_OWN_O
);
	// One clock domain, reset disables every check
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RESETN_I);
	// Reads insert exactly one wait, writes none
	a_read_wait: assert property (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I |=> !HREADYOUT_O ##1 HREADYOUT_O)
		else $error("read data phase wait wrong");
	a_write_nowait: assert property (HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I |=> HREADYOUT_O)
		else $error("write data phase stalled");
	a_resp_okay: assert property (HRESP_O == 1'b0)
		else $error("response not okay");
	// Wake follows sleep only
	a_wake_clear: assert property (!SLEEP_MODE_I |=> !WAKE_O)
		else $error("wake held outside sleep");
	a_wake_cause: assert property ($rose(WAKE_O) |-> $past(SLEEP_MODE_I))
		else $error("wake raised without sleep");
	// Clear-to-send ownership needs the request pin; handshake and clock pins are exclusive
	a_pins_flow: assert property (CLEAR_TO_SEND_OWN_O |-> !REQUEST_TO_SEND_OE_N_O)
		else $error("clear-to-send owned without request pin");
	a_pins_clock: assert property (!RATE_CLOCK_OE_N_O |-> REQUEST_TO_SEND_OE_N_O && !CLEAR_TO_SEND_OWN_O)
		else $error("rate clock shares handshake pins");
endmodule

bind asp_top asp_top_properties chk (.REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .HSEL_I(HSEL_I),
	.HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O),
	.HRESP_O(HRESP_O), .SLEEP_MODE_I(SLEEP_MODE_I), .WAKE_O(WAKE_O),
	.REQUEST_TO_SEND_OE_N_O(REQUEST_TO_SEND_OE_N_O), .RATE_CLOCK_OE_N_O(RATE_CLOCK_OE_N_O),
	.CLEAR_TO_SEND_OWN_O(CLEAR_TO_SEND_OWN_O));

// ==== tb/test_async_serial_port_config_status.sv ====
// Register-level bench of the serial port with a serial peer
module test_async_serial_port_config_status;
	import asp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, sleep = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic hrdy, tx, tx_oe_n, rts_oe_n, bclk_oe_n, rx_own, cts_own, wake, rx_irq, rx, tx_line;
	logic [7:0] c;
	logic idle = 1'b0, cts_n = 1'b0, tx_irq;
	int num_errors = 0, comparisons = 0, cyc = 0;
	// Released transmit pin is pulled up
	assign tx_line = tx_oe_n ? 1'b1 : tx;
	asp_top dut (.REF_CLK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy),
		.HREADYOUT_O(hrdy), .HRESP_O(), .HRDATA_O(hrdata), .IDLE_MODE_I(idle),
		.SLEEP_MODE_I(sleep), .SERIAL_IN_I(rx), .CLEAR_TO_SEND_N_I(cts_n), .SERIAL_OUT_O(tx),
		.SERIAL_OUT_OE_N_O(tx_oe_n), .REQUEST_TO_SEND_N_O(), .REQUEST_TO_SEND_OE_N_O(rts_oe_n),
		.RATE_CLOCK_O(), .RATE_CLOCK_OE_N_O(bclk_oe_n), .SERIAL_IN_OWN_O(rx_own),
		.CLEAR_TO_SEND_OWN_O(cts_own), .WAKE_O(wake), .TX_IRQ_O(tx_irq), .RX_IRQ_O(rx_irq));
	asp_peer #(.BIT_CLKS(8)) peer (.clk_i(clk), .line_i(tx_line), .line_o(rx));
	always #50 clk = ~clk;
	// Closing verdict
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One AHB single transfer; address held until ready, data taken at second ready edge
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		r = hrdata;
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		xfer(ASP_OFS_STATUS, 1'b0, 32'h0, q);
		chk(q, 32'h110);
		xfer(ASP_OFS_UNMAPPED, 1'b0, 32'h0, q);
		chk(q, 32'h0);
		xfer(ASP_OFS_STATUS, 1'b1, 32'h1400, q);
		xfer(ASP_OFS_MODE, 1'b1, 32'h7bdf, q);
		xfer(ASP_OFS_MODE, 1'b0, 32'h0, q);
		chk(q, 32'h3bdf);
		chk({27'h0, rts_oe_n, bclk_oe_n, cts_own, tx_oe_n, rx_own}, 32'h1a);
		// Every pin-set code with the port on
		for (int p = 0; p < 4; p++)
		begin
			xfer(ASP_OFS_MODE, 1'b1, 32'h8008 | (p << 8), q);
			xfer(ASP_OFS_MODE, 1'b0, 32'h0, q);
			chk({27'h0, rts_oe_n, bclk_oe_n, cts_own, tx_oe_n, rx_own}, {27'h0, !(p == 1 || p == 2), p != 3, p == 2, 2'b01});
		end
		xfer(ASP_OFS_MODE, 1'b1, 32'h8008, q);
		// Overfill the queue at the slow reset rate, then abort
		repeat (10) xfer(ASP_OFS_TXDATA, 1'b1, 32'h55, q);
		xfer(ASP_OFS_STATUS, 1'b0, 32'h0, q);
		chk(q & 32'h300, 32'h200);
		chk({31'h0, tx_irq}, 32'h0);
		xfer(ASP_OFS_STATUS, 1'b1, 32'h1000, q);
		xfer(ASP_OFS_STATUS, 1'b0, 32'h0, q);
		chk(q & 32'h300, 32'h100);
		chk({31'h0, tx_oe_n}, 32'h1);
		chk({31'h0, tx_irq}, 32'h1);
		xfer(ASP_OFS_STATUS, 1'b1, 32'h1400, q);
		xfer(ASP_OFS_DIVISOR, 1'b1, 32'h1, q);
		xfer(ASP_OFS_TXDATA, 1'b1, 32'ha5, q);
		peer.recv(c);
		chk({24'h0, c}, 32'ha5);
		// Break frame then self-clearing request
		xfer(ASP_OFS_STATUS, 1'b1, 32'h1c00, q);
		xfer(ASP_OFS_TXDATA, 1'b1, 32'h0, q);
		peer.recv(c);
		chk({24'h0, c}, 32'h0);
		repeat (64) @(posedge clk);
		xfer(ASP_OFS_STATUS, 1'b0, 32'h0, q);
		// Request cleared; the queued character is still shifting, so not empty yet
		chk(q & 32'hf00, 32'h400);
		// Receive one character
		peer.send(8'h3c);
		chk({31'h0, rx_irq}, 32'h1);
		xfer(ASP_OFS_RXDATA, 1'b0, 32'h0, q);
		chk(q, 32'h3c);
		// Start bit during sleep raises wake
		xfer(ASP_OFS_MODE, 1'b1, 32'h8088, q);
		sleep <= 1'b1;
		peer.send(8'h01);
		chk({31'h0, wake}, 32'h1);
		sleep <= 1'b0;
		repeat (2) @(posedge clk);
		chk({31'h0, wake}, 32'h0);
		xfer(ASP_OFS_RXDATA, 1'b0, 32'h0, q);
		chk(q, 32'h1);
		// Idle-stop freezes the receiver, so a character sent in idle is lost
		xfer(ASP_OFS_MODE, 1'b1, 32'ha208, q);
		idle <= 1'b1;
		cts_n <= 1'b1;
		peer.send(8'h5a);
		chk({31'h0, rx_irq}, 32'h0);
		idle <= 1'b0;
		// Flow pins: no start bit while clear-to-send is high
		xfer(ASP_OFS_TXDATA, 1'b1, 32'h0, q);
		repeat (20) @(posedge clk);
		chk({31'h0, tx_line}, 32'h1);
		cts_n <= 1'b0;
		peer.recv(c);
		chk({24'h0, c}, 32'h0);
		// Port off; leave one clock before checking the transmit pin enable
		xfer(ASP_OFS_MODE, 1'b1, 32'h0, q);
		@(posedge clk);
		chk({31'h0, tx_oe_n}, 32'h1);
		report_and_stop();
	end
endmodule
